// file: src/mcdp_core.sv
`timescale 1ns/1ps
module mcdp_core
   import mcdp_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic            instValid,
   input  wire mcdp_op_t        instOp,
   input  wire logic [7:0]      instImm,
   input  wire logic [PC_W-1:0] instAddr,
   input  wire logic [7:0]      memRdData,
   input  wire logic            callPush,
   input  wire logic [PC_W-1:0] callAddr,
   input  wire logic            irqPending,
   input  wire logic            wakeUp,
   input  wire logic            watchdogTimeout,
   input  wire logic            watchdogFlagClr,
   output logic                 instReady,
   output logic [7:0]           accOut,
   output logic [PC_W-1:0]      pcOut,
   output logic                 pcLoad,
   output logic                 memWrEn,
   output logic [7:0]           memWrData,
   output logic                 zeroFlag,
   output logic                 carryFlag,
   output logic                 nibbleCarryFlag,
   output logic                 overflowFlag,
   output logic                 globalIrqEnable,
   output logic                 irqService,
   output logic                 sleepEnteredFlag,
   output logic                 watchdogExpiredFlag,
   output logic                 watchdogClear,
   output logic                 clockStop
);
   mcdp_state_t     stateQ;
   mcdp_state_t     stateD;
   logic [7:0]      accQ;
   logic [PC_W-1:0] pcQ;
   logic            zeroQ;
   logic            carryQ;
   logic            nibQ;
   logic            ovQ;
   logic            irqEnQ;
   logic            sleepQ;
   logic            expiredQ;
   logic            wdClrQ;
   logic            memWrEnQ;
   logic [7:0]      memWrDataQ;
   logic            pcLoadQ;
   logic            irqSvcQ;
   logic            retiPendQ;
   logic            readyQ;
   logic            stopQ;

   logic            accept;
   logic            isReturn;
   logic            isBranch;
   logic [PC_W-1:0] stackTop;
   logic [7:0]      aluRes;
   logic            wrAcc;
   logic            wrMem;
   logic            updZero;
   logic            updCarry;
   logic            carryVal;
   logic            updNib;
   logic            nibVal;
   logic            updOv;
   logic            ovVal;

   // Instructions are only taken while running; dummy and sleep cycles refuse them.
   assign accept   = instValid && (stateQ == ST_RUN);
   assign isReturn = (instOp == OP_SUB_RETURN) || (instOp == OP_RETURN_VAL) ||
                     (instOp == OP_IRQ_RETURN);
   assign isBranch = isReturn || (instOp == OP_JUMP);

   mcdp_alu u_alu (
      .op       (instOp),
      .acc      (accQ),
      .mem      (memRdData),
      .imm      (instImm),
      .carry    (carryQ),
      .nibCarry (nibQ),
      .result   (aluRes),
      .wrAcc    (wrAcc),
      .wrMem    (wrMem),
      .updZero  (updZero),
      .updCarry (updCarry),
      .carryVal (carryVal),
      .updNib   (updNib),
      .nibVal   (nibVal),
      .updOv    (updOv),
      .ovVal    (ovVal)
   );

   mcdp_pc_stack #(
      .DEPTH (DEPTH),
      .W     (PC_W)
   ) u_stack (
      .clk      (clk),
      .nrst     (nrst),
      .push     (callPush && !(accept && isReturn)),
      .pushData (callAddr),
      .pop      (accept && isReturn),
      .topData  (stackTop)
   );

   always_comb begin
      stateD = stateQ;
      case (stateQ)
         ST_RUN: begin
            if (accept && isBranch) begin
               stateD = ST_DUMMY;
            end else if (accept && instOp == OP_SLEEP) begin
               stateD = ST_SLEEP;
            end
         end
         ST_DUMMY: stateD = ST_RUN;
         ST_SLEEP: begin
            if (wakeUp) begin
               stateD = ST_RUN;
            end
         end
         default: stateD = ST_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stateQ <= ST_RUN;
         readyQ <= 1'b1;
         stopQ  <= 1'b0;
      end else begin
         stateQ <= stateD;
         readyQ <= (stateD == ST_RUN);
         stopQ  <= (stateD == ST_SLEEP);
      end
   end

   // Accumulator and memory are retained through sleep since nothing is accepted there.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         accQ <= ACC_RST;
      end else if (accept && wrAcc) begin
         accQ <= aluRes;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         memWrEnQ   <= 1'b0;
         memWrDataQ <= ACC_RST;
      end else begin
         memWrEnQ <= accept && wrMem;
         if (accept && wrMem) begin
            memWrDataQ <= aluRes;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zeroQ  <= 1'b0;
         carryQ <= 1'b0;
         nibQ   <= 1'b0;
         ovQ    <= 1'b0;
      end else if (accept) begin
         if (updZero) begin
            zeroQ <= (aluRes == ADJ_NONE);
         end
         if (updCarry) begin
            carryQ <= carryVal;
         end
         if (updNib) begin
            nibQ <= nibVal;
         end
         if (updOv) begin
            ovQ <= ovVal;
         end
      end
   end

   // The dummy cycle after a branch shows the new counter with a load strobe to fetch.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pcQ     <= PC_RST;
         pcLoadQ <= 1'b0;
      end else begin
         pcLoadQ <= accept && isBranch;
         if (accept) begin
            if (instOp == OP_JUMP) begin
               pcQ <= instAddr;
            end else if (isReturn) begin
               pcQ <= stackTop;
            end else begin
               pcQ <= pcQ + PC_STEP;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqEnQ    <= 1'b0;
         retiPendQ <= 1'b0;
         irqSvcQ   <= 1'b0;
      end else begin
         if (accept && instOp == OP_IRQ_RETURN) begin
            irqEnQ <= 1'b1;
         end
         retiPendQ <= accept && (instOp == OP_IRQ_RETURN);
         // A request already waiting is handed to the vector logic right after the return.
         irqSvcQ   <= retiPendQ && irqPending && irqEnQ;
      end
   end

   // A timeout in the same cycle as a clear or sleep entry wins, so it is never lost.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sleepQ   <= 1'b0;
         expiredQ <= 1'b0;
         wdClrQ   <= 1'b0;
      end else begin
         wdClrQ <= accept && (instOp == OP_SLEEP);
         if (watchdogTimeout) begin
            expiredQ <= 1'b1;
         end else if (watchdogFlagClr || (accept && instOp == OP_SLEEP)) begin
            expiredQ <= 1'b0;
         end
         if (accept && instOp == OP_SLEEP) begin
            sleepQ <= 1'b1;
         end else if (watchdogFlagClr) begin
            sleepQ <= 1'b0;
         end
      end
   end

   assign instReady           = readyQ;
   assign accOut              = accQ;
   assign pcOut               = pcQ;
   assign pcLoad              = pcLoadQ;
   assign memWrEn             = memWrEnQ;
   assign memWrData           = memWrDataQ;
   assign zeroFlag            = zeroQ;
   assign carryFlag           = carryQ;
   assign nibbleCarryFlag     = nibQ;
   assign overflowFlag        = ovQ;
   assign globalIrqEnable     = irqEnQ;
   assign irqService          = irqSvcQ;
   assign sleepEnteredFlag    = sleepQ;
   assign watchdogExpiredFlag = expiredQ;
   assign watchdogClear       = wdClrQ;
   assign clockStop           = stopQ;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_inv_mem_write: assert property (accept && instOp == OP_INV_MEM |=>
      memWrEn && memWrData == ~$past(memRdData) && zeroFlag == (memWrData == ADJ_NONE))
      else $error("invert to memory wrong");
   a_inv_acc_only: assert property (accept && instOp == OP_INV_ACC |=>
      !memWrEn && accOut == ~$past(memRdData) && carryFlag == $past(carryQ))
      else $error("invert to accumulator wrong");
   a_adjust_none: assert property (accept && instOp == OP_DEC_ADJUST &&
      accQ[3:0] <= NIB_LIMIT && !nibQ && accQ[7:4] <= NIB_LIMIT && !carryQ |=>
      memWrData == $past(accQ)) else $error("adjust changed a valid value");
   a_adjust_full: assert property (accept && instOp == OP_DEC_ADJUST &&
      nibQ && carryQ |=> memWrData == 8'($past(accQ) + (ADJ_LOW | ADJ_HIGH)))
      else $error("adjust addend wrong");
   a_adjust_flags: assert property (accept && instOp == OP_DEC_ADJUST |=>
      memWrEn && $stable(zeroFlag) && $stable(accOut) && $stable(overflowFlag))
      else $error("adjust touched more than carry");
   a_decr_mem: assert property (accept && instOp == OP_DECR_MEM |=>
      memWrData == 8'($past(memRdData) - BYTE_ONE)) else $error("decrement wrong");
   a_incr_acc: assert property (accept && instOp == OP_INCR_ACC |=>
      !memWrEn && accOut == 8'($past(memRdData) + BYTE_ONE)) else $error("increment wrong");
   a_sleep_entry: assert property (accept && instOp == OP_SLEEP && !watchdogTimeout |=>
      sleepEnteredFlag && !watchdogExpiredFlag && watchdogClear && clockStop && !instReady)
      else $error("sleep entry wrong");
   a_jump_two: assert property (accept && instOp == OP_JUMP |=>
      pcOut == $past(instAddr) && pcLoad && !instReady ##1 instReady)
      else $error("jump timing wrong");
   a_move_flags: assert property (accept && instOp == OP_MOVE_I2A |=>
      accOut == $past(instImm) && $stable(zeroFlag) && $stable(carryFlag))
      else $error("move changed flags");
   a_interrupt_return_enable: assert property (accept && instOp == OP_IRQ_RETURN |=>
      globalIrqEnable && pcLoad) else $error("interrupt return wrong");
   a_sbc_carry: assert property (accept && instOp == OP_SUB_BORROW |=>
      carryFlag == ($past(accQ) >= 9'($past(memRdData)) + 9'(!$past(carryQ))))
      else $error("borrow carry wrong");
   a_rol_value: assert property (accept && instOp == OP_ROL_ACC |=>
      accOut == {$past(memRdData[6:0]), $past(memRdData[7])} && $stable(carryFlag))
      else $error("rotate left wrong");

   c_jump: cover property (accept && instOp == OP_JUMP ##2 accept);
   c_sleep_wake: cover property (stateQ == ST_SLEEP ##1 wakeUp ##1 instReady);
   c_interrupt_return_irq: cover property (accept && instOp == OP_IRQ_RETURN ##2 irqService);
   c_adjust_carry: cover property (accept && instOp == OP_DEC_ADJUST && !carryQ ##1 carryFlag);
endmodule // mcdp_core

// file: src/mcdp_pkg.sv
// Contract
// - Invert memory byte in place, zero flag only.
// - Inverted memory byte to accumulator, zero only.
// - Low nibble plus six if above nine or nibble carry.
// - High nibble plus six if above nine or carry.
// - Adjusted value to memory, only carry may change.
// - Decrement memory byte to memory or accumulator, zero.
// - Increment memory byte to memory or accumulator, zero.
// - Sleep: stop, clear watchdog, set sleep, clear expired.
// - Jump loads address, two cycles, no flags.
// - Moves alter no status flag.
// - No-operation changes nothing, execution proceeds.
// - OR into accumulator or memory, zero flag only.
// - Return pops program counter, no flags.
// - Return with value also loads accumulator.
// - Interrupt return pops, enables interrupts, pending serviced.
// - Rotate left, bit seven into bit zero.
// - Rotate left through carry.
// - Rotate right, bit zero into bit seven.
// - Rotate right through carry.
// - Accumulator minus memory minus inverted carry.
// - Carry clear if negative, set otherwise.
// - Subtract updates overflow, zero, nibble carry, carry.
package mcdp_pkg;
   localparam int        DATA_W      = 8;
   localparam int        PC_W        = 13;
   localparam int        STACK_DEPTH = 8;
   localparam logic [3:0] NIB_LIMIT  = 4'h9;
   localparam logic [7:0] ADJ_LOW    = 8'h06;
   localparam logic [7:0] ADJ_HIGH   = 8'h60;
   localparam logic [7:0] ADJ_NONE   = 8'h00;
   localparam logic [7:0] BYTE_ONE   = 8'h01;
   localparam logic [7:0] ACC_RST    = 8'h00;
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [12:0] PC_STEP   = 13'h0001;

   typedef enum logic [4:0] {
      OP_NOP, OP_INV_MEM, OP_INV_ACC, OP_DEC_ADJUST, OP_DECR_MEM, OP_DECR_ACC,
      OP_INCR_MEM, OP_INCR_ACC, OP_JUMP, OP_MOVE_M2A, OP_MOVE_I2A, OP_MOVE_A2M,
      OP_OR_MEM, OP_OR_IMM, OP_OR_TO_MEM, OP_SUB_RETURN, OP_RETURN_VAL,
      OP_IRQ_RETURN, OP_ROL_MEM, OP_ROL_ACC, OP_ROLC_MEM, OP_ROLC_ACC,
      OP_ROR_MEM, OP_ROR_ACC, OP_RORC_MEM, OP_RORC_ACC, OP_SUB_BORROW, OP_SLEEP
   } mcdp_op_t;

   typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_SLEEP} mcdp_state_t;
endpackage

// file: src/mcdp_alu.sv
`timescale 1ns/1ps
module mcdp_alu
   import mcdp_pkg::*;
(
   input  wire mcdp_op_t    op,
   input  wire logic [7:0]  acc,
   input  wire logic [7:0]  mem,
   input  wire logic [7:0]  imm,
   input  wire logic        carry,
   input  wire logic        nibCarry,
   output logic      [7:0]  result,
   output logic             wrAcc,
   output logic             wrMem,
   output logic             updZero,
   output logic             updCarry,
   output logic             carryVal,
   output logic             updNib,
   output logic             nibVal,
   output logic             updOv,
   output logic             ovVal
);
   logic [8:0] diff;
   logic [4:0] lowDiff;
   logic [8:0] adjSum;
   logic [7:0] addend;

   always_comb begin
      diff    = {1'b0, acc} - {1'b0, mem} - {8'h00, ~carry};
      lowDiff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, ~carry};
      addend  = ADJ_NONE;
      if (acc[3:0] > NIB_LIMIT || nibCarry) addend = addend | ADJ_LOW;
      if (acc[7:4] > NIB_LIMIT || carry) addend = addend | ADJ_HIGH;
      adjSum  = {1'b0, acc} + {1'b0, addend};
   end

   always_comb begin
      result   = mem;
      wrAcc    = 1'b0;
      wrMem    = 1'b0;
      updZero  = 1'b0;
      updCarry = 1'b0;
      carryVal = carry;
      updNib   = 1'b0;
      nibVal   = nibCarry;
      updOv    = 1'b0;
      ovVal    = 1'b0;
      case (op)
         OP_INV_MEM:    begin result = ~mem; wrMem = 1'b1; updZero = 1'b1; end
         OP_INV_ACC:    begin result = ~mem; wrAcc = 1'b1; updZero = 1'b1; end
         OP_DEC_ADJUST: begin
            result   = adjSum[7:0];
            wrMem    = 1'b1;
            updCarry = 1'b1;
            carryVal = carry | adjSum[8];
         end
         OP_DECR_MEM:   begin result = mem - BYTE_ONE; wrMem = 1'b1; updZero = 1'b1; end
         OP_DECR_ACC:   begin result = mem - BYTE_ONE; wrAcc = 1'b1; updZero = 1'b1; end
         OP_INCR_MEM:   begin result = mem + BYTE_ONE; wrMem = 1'b1; updZero = 1'b1; end
         OP_INCR_ACC:   begin result = mem + BYTE_ONE; wrAcc = 1'b1; updZero = 1'b1; end
         OP_MOVE_M2A:   begin result = mem; wrAcc = 1'b1; end
         OP_MOVE_I2A,
         OP_RETURN_VAL: begin result = imm; wrAcc = 1'b1; end
         OP_MOVE_A2M:   begin result = acc; wrMem = 1'b1; end
         OP_OR_MEM:     begin result = acc | mem; wrAcc = 1'b1; updZero = 1'b1; end
         OP_OR_IMM:     begin result = acc | imm; wrAcc = 1'b1; updZero = 1'b1; end
         OP_OR_TO_MEM:  begin result = acc | mem; wrMem = 1'b1; updZero = 1'b1; end
         OP_ROL_MEM:    begin result = {mem[6:0], mem[7]}; wrMem = 1'b1; end
         OP_ROL_ACC:    begin result = {mem[6:0], mem[7]}; wrAcc = 1'b1; end
         OP_ROR_MEM:    begin result = {mem[0], mem[7:1]}; wrMem = 1'b1; end
         OP_ROR_ACC:    begin result = {mem[0], mem[7:1]}; wrAcc = 1'b1; end
         OP_ROLC_MEM, OP_ROLC_ACC: begin
            result   = {mem[6:0], carry};
            wrMem    = (op == OP_ROLC_MEM);
            wrAcc    = (op == OP_ROLC_ACC);
            updCarry = 1'b1;
            carryVal = mem[7];
         end
         OP_RORC_MEM, OP_RORC_ACC: begin
            result   = {carry, mem[7:1]};
            wrMem    = (op == OP_RORC_MEM);
            wrAcc    = (op == OP_RORC_ACC);
            updCarry = 1'b1;
            carryVal = mem[0];
         end
         OP_SUB_BORROW: begin
            result   = diff[7:0];
            wrAcc    = 1'b1;
            updZero  = 1'b1;
            updCarry = 1'b1;
            carryVal = ~diff[8];
            updNib   = 1'b1;
            nibVal   = ~lowDiff[4];
            updOv    = 1'b1;
            ovVal    = (acc[7] != mem[7]) && (diff[7] != acc[7]);
         end
         default:       begin result = mem; end
      endcase
   end
endmodule // mcdp_alu

// file: src/mcdp_pc_stack.sv
`timescale 1ns/1ps
module mcdp_pc_stack #(
   parameter int DEPTH = 8,
   parameter int W     = 13
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         push,
   input  wire logic [W-1:0] pushData,
   input  wire logic         pop,
   output logic      [W-1:0] topData
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  slots [DEPTH];
   logic [PW-1:0] ptrQ;

   // The pointer wraps like a hardware return stack; overflow overwrites the oldest entry.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptrQ <= '0;
      end else if (push) begin
         ptrQ <= ptrQ + 1'b1;
      end else if (pop) begin
         ptrQ <= ptrQ - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         slots[ptrQ] <= pushData;
      end
   end

   assign topData = slots[ptrQ - 1'b1];
endmodule // mcdp_pc_stack

// file: testbench/mcdp_mem_model.sv
`timescale 1ns/1ps
module mcdp_mem_model (
   input  wire logic       clk,
   input  wire logic       instValid,
   input  wire logic       memWrEn,
   input  wire logic [7:0] memWrData,
   output logic      [7:0] memRdData
);
   logic [7:0] cell_q;

   // Between offered instructions the byte is not valid, so show its inverse: a design
   // that samples memory at the wrong moment then picks up a visibly wrong operand.
   assign memRdData = instValid ? cell_q : ~cell_q;

   // Plain always so the bench can preload the byte between writes.
   always @(posedge clk) begin
      if (memWrEn) begin
         cell_q <= memWrData;
      end
   end
endmodule // mcdp_mem_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import mcdp_pkg::*;
;
   logic            clk = 1'h0;
   logic            nrst = 1'h0;
   logic            instValid = 1'h0;
   mcdp_op_t        instOp = OP_NOP;
   logic [7:0]      instImm = 8'h00;
   logic [PC_W-1:0] instAddr = 13'h0000;
   logic [7:0]      memRdData;
   logic            callPush = 1'h0;
   logic [PC_W-1:0] callAddr = 13'h0000;
   logic            irqPending = 1'h0;
   logic            wakeUp = 1'h0;
   logic            watchdogTimeout = 1'h0;
   logic            watchdogFlagClr = 1'h0;
   logic            instReady, pcLoad, memWrEn, zeroFlag, carryFlag, nibbleCarryFlag;
   logic            overflowFlag, globalIrqEnable, irqService, sleepEnteredFlag;
   logic            watchdogExpiredFlag, watchdogClear, clockStop;
   logic [7:0]      accOut, memWrData;
   logic [PC_W-1:0] pcOut;
   int              fails = 0;
   int              testsRun = 0;

   mcdp_core mcdp_core_inst (.clk, .nrst, .instValid, .instOp, .instImm, .instAddr,
      .memRdData, .callPush, .callAddr, .irqPending, .wakeUp, .watchdogTimeout,
      .watchdogFlagClr, .instReady, .accOut, .pcOut, .pcLoad, .memWrEn, .memWrData,
      .zeroFlag, .carryFlag, .nibbleCarryFlag, .overflowFlag, .globalIrqEnable,
      .irqService, .sleepEnteredFlag, .watchdogExpiredFlag, .watchdogClear, .clockStop);

   mcdp_mem_model mcdp_mem_model_inst (.clk, .instValid, .memWrEn, .memWrData, .memRdData);

   always #12.5 clk = ~clk;

   task automatic finishTest();
      $display("checks %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      testsRun++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      testsRun++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk13(input string n, input logic [12:0] e, input logic [12:0] g);
      testsRun++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // Called at a falling edge; returns at the falling edge where results are visible.
   // The leading idle edge keeps instValid from being lowered and raised in one step.
   task automatic exec(input mcdp_op_t o, input logic [7:0] m, input logic [7:0] i);
      int k;
      k = 0;
      @(negedge clk);
      while (instReady !== 1'h1) begin
         k++;
         if (k > 20) begin
            fails++;
            finishTest();
         end
         @(negedge clk);
      end
      mcdp_mem_model_inst.cell_q = m;
      instValid = 1'h1;
      instOp    = o;
      instImm   = i;
      @(negedge clk);
      instValid = 1'h0;
   endtask

   task automatic setCarry(input logic b);
      exec(OP_ROLC_ACC, {b, 7'h00}, 8'h00);
   endtask

   task automatic push(input logic [12:0] a);
      callPush = 1'h1;
      callAddr = a;
      @(negedge clk);
      callPush = 1'h0;
   endtask

   task automatic checkDest(input logic isMem, input logic [7:0] r);
      chk1("memWrEn", isMem, memWrEn);
      if (isMem) chk8("memWrData", r, memWrData);
      else chk8("accOut", r, accOut);
   endtask

   task automatic testUnary();
      mcdp_op_t   op [6] = '{OP_INV_MEM, OP_INV_ACC, OP_DECR_MEM, OP_DECR_ACC,
                             OP_INCR_MEM, OP_INCR_ACC};
      logic [7:0] m [6] = '{8'hFF, 8'h5A, 8'h01, 8'h00, 8'hFF, 8'h7F};
      logic [7:0] r [6] = '{8'h00, 8'hA5, 8'h00, 8'hFF, 8'h00, 8'h80};
      for (int i = 0; i < 6; i++) begin
         setCarry(1'h1);
         exec(op[i], m[i], 8'h00);
         checkDest(i % 2 == 0, r[i]);
         chk1("zeroFlag", r[i] == 8'h00, zeroFlag);
         chk1("carryFlag", 1'h1, carryFlag);
      end
      $display("test unary done");
   endtask

   task automatic testRotate();
      mcdp_op_t   op [8] = '{OP_ROL_MEM, OP_ROL_ACC, OP_ROLC_MEM, OP_ROLC_ACC,
                             OP_ROR_MEM, OP_ROR_ACC, OP_RORC_MEM, OP_RORC_ACC};
      logic [7:0] r [8] = '{8'h03, 8'h03, 8'h02, 8'h02, 8'hC0, 8'hC0, 8'h40, 8'h40};
      for (int i = 0; i < 8; i++) begin
         setCarry(1'h0);
         exec(op[i], 8'h81, 8'h00);
         checkDest(i % 2 == 0, r[i]);
         chk1("carryFlag", i inside {2, 3, 6, 7}, carryFlag);
      end
      setCarry(1'h1);
      exec(OP_RORC_ACC, 8'h00, 8'h00);
      checkDest(1'h0, 8'h80);
      chk1("carryFlag", 1'h0, carryFlag);
      setCarry(1'h1);
      exec(OP_ROLC_MEM, 8'h00, 8'h00);
      checkDest(1'h1, 8'h01);
      $display("test rotate done");
   endtask

   task automatic testDecimal();
      logic [7:0] a [4] = '{8'hAA, 8'h3C, 8'h45, 8'h12};
      logic [7:0] r [4] = '{8'h10, 8'h42, 8'hA5, 8'h12};
      logic       ci [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
      logic       co [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
      for (int i = 0; i < 4; i++) begin
         setCarry(ci[i]);
         exec(OP_MOVE_I2A, 8'h00, a[i]);
         exec(OP_DEC_ADJUST, 8'h00, 8'h00);
         checkDest(1'h1, r[i]);
         chk1("carryFlag", co[i], carryFlag);
         chk8("accOut", a[i], accOut);
      end
      $display("test decimal done");
   endtask

   task automatic testSubtract();
      logic [7:0] a [4] = '{8'h19, 8'h05, 8'h80, 8'h05};
      logic [7:0] m [4] = '{8'h10, 8'h05, 8'h01, 8'h05};
      logic [7:0] r [4] = '{8'h09, 8'hFF, 8'h7F, 8'h00};
      logic       ci [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
      logic [3:0] f [4] = '{4'hC, 4'h0, 4'h9, 4'hE};
      for (int i = 0; i < 4; i++) begin
         setCarry(ci[i]);
         exec(OP_MOVE_I2A, 8'h00, a[i]);
         exec(OP_SUB_BORROW, m[i], 8'h00);
         chk8("accOut", r[i], accOut);
         chk1("carryFlag", f[i][3], carryFlag);
         chk1("nibbleCarryFlag", f[i][2], nibbleCarryFlag);
         chk1("zeroFlag", f[i][1], zeroFlag);
         chk1("overflowFlag", f[i][0], overflowFlag);
         if (i == 0) begin
            // Low nibble 9 is adjusted only because the nibble carry is set.
            exec(OP_DEC_ADJUST, 8'h00, 8'h00);
            checkDest(1'h1, 8'h6F);
         end
      end
      $display("test subtract done");
   endtask

   task automatic testMoveOr();
      exec(OP_INV_MEM, 8'hFF, 8'h00);
      setCarry(1'h1);
      exec(OP_MOVE_I2A, 8'h00, 8'h55);
      checkDest(1'h0, 8'h55);
      exec(OP_MOVE_A2M, 8'h33, 8'h00);
      checkDest(1'h1, 8'h55);
      exec(OP_MOVE_M2A, 8'hAA, 8'h00);
      checkDest(1'h0, 8'hAA);
      chk1("zeroFlag", 1'h1, zeroFlag);
      chk1("carryFlag", 1'h1, carryFlag);
      exec(OP_OR_IMM, 8'h00, 8'h05);
      checkDest(1'h0, 8'hAF);
      chk1("zeroFlag", 1'h0, zeroFlag);
      exec(OP_OR_MEM, 8'h50, 8'h00);
      checkDest(1'h0, 8'hFF);
      exec(OP_MOVE_I2A, 8'h00, 8'h00);
      exec(OP_OR_TO_MEM, 8'h00, 8'h00);
      checkDest(1'h1, 8'h00);
      chk1("zeroFlag", 1'h1, zeroFlag);
      exec(OP_NOP, 8'h3C, 8'h00);
      chk1("memWrEn", 1'h0, memWrEn);
      chk1("instReady", 1'h1, instReady);
      chk8("accOut", 8'h00, accOut);
      chk1("zeroFlag", 1'h1, zeroFlag);
      $display("test move or done");
   endtask

   task automatic testBranch();
      setCarry(1'h1);
      instAddr = 13'h1ABC;
      exec(OP_JUMP, 8'h00, 8'h00);
      chk13("pcOut", 13'h1ABC, pcOut);
      chk1("pcLoad", 1'h1, pcLoad);
      chk1("instReady", 1'h0, instReady);
      chk1("carryFlag", 1'h1, carryFlag);
      @(negedge clk);
      chk1("instReady", 1'h1, instReady);
      push(13'h0123);
      exec(OP_SUB_RETURN, 8'h00, 8'h00);
      chk13("pcOut", 13'h0123, pcOut);
      push(13'h0456);
      exec(OP_RETURN_VAL, 8'h00, 8'h77);
      chk13("pcOut", 13'h0456, pcOut);
      chk8("accOut", 8'h77, accOut);
      irqPending = 1'h1;
      push(13'h0789);
      chk1("globalIrqEnable", 1'h0, globalIrqEnable);
      exec(OP_IRQ_RETURN, 8'h00, 8'h00);
      chk13("pcOut", 13'h0789, pcOut);
      chk1("globalIrqEnable", 1'h1, globalIrqEnable);
      @(negedge clk);
      chk1("irqService", 1'h1, irqService);
      irqPending = 1'h0;
      $display("test branch done");
   endtask

   task automatic testSleep();
      exec(OP_MOVE_I2A, 8'h00, 8'h3C);
      watchdogTimeout = 1'h1;
      @(negedge clk);
      watchdogTimeout = 1'h0;
      chk1("watchdogExpiredFlag", 1'h1, watchdogExpiredFlag);
      exec(OP_SLEEP, 8'h00, 8'h00);
      chk1("sleepEnteredFlag", 1'h1, sleepEnteredFlag);
      chk1("watchdogExpiredFlag", 1'h0, watchdogExpiredFlag);
      chk1("watchdogClear", 1'h1, watchdogClear);
      chk1("clockStop", 1'h1, clockStop);
      // An instruction offered while asleep must be ignored.
      @(negedge clk);
      instValid = 1'h1;
      instOp    = OP_MOVE_I2A;
      instImm   = 8'h00;
      @(negedge clk);
      instValid = 1'h0;
      chk1("instReady", 1'h0, instReady);
      chk8("accOut", 8'h3C, accOut);
      wakeUp = 1'h1;
      @(negedge clk);
      wakeUp = 1'h0;
      chk1("clockStop", 1'h0, clockStop);
      watchdogFlagClr = 1'h1;
      @(negedge clk);
      watchdogFlagClr = 1'h0;
      chk1("sleepEnteredFlag", 1'h0, sleepEnteredFlag);
      $display("test sleep done");
   endtask

   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      nrst = 1'h1;
      chk8("accOut", 8'h00, accOut);
      chk13("pcOut", 13'h0000, pcOut);
      chk1("instReady", 1'h1, instReady);
      testUnary();
      testRotate();
      testDecimal();
      testSubtract();
      testMoveOr();
      testBranch();
      testSleep();
      finishTest();
   end
endmodule // tb_top
